//--- common/usf_pkg.sv
package usf_pkg;

   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] USF_STAT_OFS = 8'h00;
   localparam logic [7:0] USF_DATA_OFS = 8'h04;
   localparam logic [7:0] USF_CTRL_OFS = 8'h08;
   localparam logic [7:0] USF_BAUD_OFS = 8'h0C;

   // ----------------------------------------------------------------
   // Status bit positions
   // ----------------------------------------------------------------
   localparam int USF_TXE_BIT = 7;
   localparam int USF_TXC_BIT = 6;
   localparam int USF_RXF_BIT = 5;
   localparam int USF_IDLE_BIT = 4;
   localparam int USF_OR_BIT = 3;
   localparam int USF_NOISE_BIT = 2;
   localparam int USF_FRM_BIT = 1;
   localparam int USF_PAR_BIT = 0;

   // ----------------------------------------------------------------
   // Control bit positions
   // ----------------------------------------------------------------
   localparam int USF_PODD_BIT = 0;
   localparam int USF_PON_BIT = 1;
   localparam int USF_IAS_BIT = 2;
   localparam int USF_M9_BIT = 3;
   localparam int USF_BRK_BIT = 4;
   localparam int USF_TXSW_BIT = 5;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] USF_STAT_RST = 8'hC0;
   localparam logic [7:0] USF_CTRL_RST = 8'h00;
   localparam logic [7:0] USF_CTRL_MASK = 8'h3F;
   localparam logic [15:0] USF_BAUD_RST = 16'h0000;

   // ----------------------------------------------------------------
   // Oversampling phases (16 ticks per bit) and frame counts
   // ----------------------------------------------------------------
   localparam logic [3:0] USF_OS_LAST = 4'hF;
   localparam logic [3:0] USF_START_FIRST = 4'h3;
   localparam logic [3:0] USF_START_LAST = 4'h9;
   localparam logic [3:0] USF_BIT_FIRST = 4'h7;
   localparam logic [3:0] USF_BIT_LAST = 4'h9;
   localparam logic [3:0] USF_STOP_DONE = 4'hA;
   localparam logic [2:0] USF_START_SAMPLES = 3'h7;
   localparam logic [2:0] USF_BIT_SAMPLES = 3'h3;
   localparam logic [2:0] USF_START_REJECT = 3'h4;
   localparam logic [2:0] USF_BIT_MAJORITY = 3'h2;
   localparam logic [3:0] USF_DATA8_LAST = 4'h7;
   localparam logic [3:0] USF_DATA9_LAST = 4'h8;
   localparam logic [3:0] USF_FRAME8_LAST = 4'h9;
   localparam logic [3:0] USF_FRAME9_LAST = 4'hA;
   // Idle line: 10 or 11 bit times in ticks
   localparam logic [7:0] USF_IDLE8_TICKS = 8'hA0;
   localparam logic [7:0] USF_IDLE9_TICKS = 8'hB0;

   // ----------------------------------------------------------------
   // State machines
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      USF_RX_IDLE = 4'b0001,
      USF_RX_START = 4'b0010,
      USF_RX_DATA = 4'b0100,
      USF_RX_STOP = 4'b1000
   } usf_rx_t;

   typedef enum logic [1:0] {
      USF_TX_IDLE = 2'b01,
      USF_TX_SHIFT = 2'b10
   } usf_tx_t;

endpackage : usf_pkg

//--- src/usf_status_flags.sv
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
module usf_status_flags (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Serial line
   input wire logic rxd,
   output logic txd
);
   import usf_pkg::*;

   function automatic logic noisy(input logic [2:0] ones, input logic [2:0] n);
      return (ones != 3'h0) && (ones != n);
   endfunction : noisy

   function automatic logic in_win(input logic [3:0] ph, input logic [3:0] lo,
                                   input logic [3:0] hi);
      return (ph >= lo) && (ph <= hi);
   endfunction : in_win

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [7:0] flags_q, flags_d, arm_q, arm_d, ctrl_q, ctrl_d;
   logic [7:0] txbuf_q, txbuf_d, rxbuf_q, rxbuf_d;
   logic [15:0] baud_q, baud_d, div_q, div_d;
   logic [31:0] prdata_q, prdata_d;
   logic cplt_cond_q, cplt_cond_d, pre_q, pre_d, brk_q, brk_d;
   logic rx_s1_q, rx_s2_q;
   usf_tx_t tx_st_q, tx_st_d;
   logic [10:0] tx_sh_q, tx_sh_d;
   logic [3:0] tx_ph_q, tx_ph_d, tx_bit_q, tx_bit_d;
   logic txd_q, txd_d;
   usf_rx_t rx_st_q, rx_st_d;
   logic [3:0] rx_ph_q, rx_ph_d, rx_bit_q, rx_bit_d;
   logic [2:0] ones_q, ones_d;
   logic [8:0] rx_sh_q, rx_sh_d;
   logic noise_q, noise_d, idle_en_q, idle_en_d, idle_arm_q, idle_arm_d;
   logic [7:0] idle_cnt_q, idle_cnt_d;
   logic acc, wr_data, rd_data, rd_stat, wr_ctrl, mapped, os_tick;
   logic txsw_rise, brk_wr, tx_take, pre_taken, brk_taken;
   logic rx_done, rx_stop, rx_perr, idle_hit, rx_accept;
   logic [7:0] rx_char, fset, fclr, idle_ticks;
   logic [3:0] tx_last;

   assign prdata = prdata_q;
   assign pready = 1'b1;
   assign txd = txd_q;

   // ----------------------------------------------------------------
   // Bus decode, flags and registers
   // ----------------------------------------------------------------
   always_comb begin
      acc = psel & penable;
      mapped = (paddr == USF_STAT_OFS) | (paddr == USF_DATA_OFS) |
               (paddr == USF_CTRL_OFS) | (paddr == USF_BAUD_OFS);
      pslverr = acc & ~mapped;
      rd_stat = acc & ~pwrite & (paddr == USF_STAT_OFS);
      wr_data = acc & pwrite & (paddr == USF_DATA_OFS);
      rd_data = acc & ~pwrite & (paddr == USF_DATA_OFS);
      wr_ctrl = acc & pwrite & (paddr == USF_CTRL_OFS);
      txsw_rise = wr_ctrl & pwdata[USF_TXSW_BIT] & ~ctrl_q[USF_TXSW_BIT];
      brk_wr = wr_ctrl & pwdata[USF_BRK_BIT];
      // Status offset has no write path at all
      ctrl_d = wr_ctrl ? (pwdata[7:0] & USF_CTRL_MASK) : ctrl_q;
      baud_d = (acc & pwrite & (paddr == USF_BAUD_OFS)) ? pwdata[15:0] : baud_q;
      txbuf_d = wr_data ? pwdata[7:0] : txbuf_q;
      os_tick = (div_q >= baud_q);
      div_d = os_tick ? 16'h0000 : div_q + 16'h0001;
      // Read data is captured in the setup phase so it stays stable in access
      prdata_d = prdata_q;
      if (psel & ~penable & ~pwrite) begin
         case (paddr)
            USF_STAT_OFS: prdata_d = {24'h0000_00, flags_q};
            USF_DATA_OFS: prdata_d = {24'h0000_00, rxbuf_q};
            USF_CTRL_OFS: prdata_d = {24'h0000_00, ctrl_q};
            USF_BAUD_OFS: prdata_d = {16'h0000, baud_q};
            default: prdata_d = 32'h0000_0000;
         endcase
      end
      // Clears only land on flags that a status read saw set
      fclr = 8'h00;
      fclr[USF_TXE_BIT] = wr_data & arm_q[USF_TXE_BIT];
      fclr[USF_TXC_BIT] = arm_q[USF_TXC_BIT] & (wr_data | txsw_rise | brk_wr);
      fclr[USF_RXF_BIT] = rd_data & arm_q[USF_RXF_BIT];
      fclr[USF_IDLE_BIT] = rd_data & arm_q[USF_IDLE_BIT];
      fclr[USF_OR_BIT] = rd_data & arm_q[USF_OR_BIT];
      fclr[USF_NOISE_BIT] = rd_data & arm_q[USF_NOISE_BIT];
      fclr[USF_FRM_BIT] = rd_data & arm_q[USF_FRM_BIT];
      fclr[USF_PAR_BIT] = rd_data & arm_q[USF_PAR_BIT];
      rx_accept = rx_done & (~flags_q[USF_RXF_BIT] | fclr[USF_RXF_BIT]);
      fset = 8'h00;
      fset[USF_TXE_BIT] = tx_take;
      cplt_cond_d = flags_q[USF_TXE_BIT] & (tx_st_q == USF_TX_IDLE) & ~pre_q & ~brk_q &
                    ~ctrl_q[USF_BRK_BIT];
      fset[USF_TXC_BIT] = cplt_cond_d & ~cplt_cond_q;
      fset[USF_RXF_BIT] = rx_accept;
      fset[USF_IDLE_BIT] = idle_hit;
      fset[USF_OR_BIT] = rx_done & ~rx_accept;
      fset[USF_NOISE_BIT] = rx_accept & noise_d;
      fset[USF_FRM_BIT] = rx_accept & ~rx_stop;
      fset[USF_PAR_BIT] = rx_accept & ctrl_q[USF_PON_BIT] & rx_perr;
      // A set in the same cycle as its clear wins
      flags_d = (flags_q & ~fclr) | fset;
      // A set after the read disarms, so that the newer event survives
      arm_d = (rd_stat ? prdata_q[7:0] : (arm_q & ~fclr)) & ~fset;
      // Overrun drops the character and its error bits
      rxbuf_d = rx_accept ? rx_char : rxbuf_q;
      idle_arm_d = (idle_arm_q | rx_accept) & ~idle_hit;
      pre_d = (pre_q | txsw_rise) & ~pre_taken;
      brk_d = (brk_q | brk_wr) & ~brk_taken;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_q <= USF_STAT_RST;
         arm_q <= 8'h00;
         ctrl_q <= USF_CTRL_RST;
         baud_q <= USF_BAUD_RST;
         div_q <= 16'h0000;
         txbuf_q <= 8'h00;
         rxbuf_q <= 8'h00;
         prdata_q <= 32'h0000_0000;
         cplt_cond_q <= 1'b1;
         pre_q <= 1'b0;
         brk_q <= 1'b0;
         idle_arm_q <= 1'b0;
         rx_s1_q <= 1'b1;
         rx_s2_q <= 1'b1;
      end else begin
         flags_q <= flags_d;
         arm_q <= arm_d;
         ctrl_q <= ctrl_d;
         baud_q <= baud_d;
         div_q <= div_d;
         txbuf_q <= txbuf_d;
         rxbuf_q <= rxbuf_d;
         prdata_q <= prdata_d;
         cplt_cond_q <= cplt_cond_d;
         pre_q <= pre_d;
         brk_q <= brk_d;
         idle_arm_q <= idle_arm_d;
         rx_s1_q <= rxd;
         rx_s2_q <= rx_s1_q;
      end
   end

   // ----------------------------------------------------------------
   // Transmitter
   // ----------------------------------------------------------------
   always_comb begin
      tx_st_d = tx_st_q;
      tx_sh_d = tx_sh_q;
      tx_ph_d = tx_ph_q;
      tx_bit_d = tx_bit_q;
      tx_take = 1'b0;
      pre_taken = 1'b0;
      brk_taken = 1'b0;
      tx_last = ctrl_q[USF_M9_BIT] ? USF_FRAME9_LAST : USF_FRAME8_LAST;
      case (tx_st_q)
         USF_TX_IDLE: begin
            tx_ph_d = 4'h0;
            tx_bit_d = 4'h0;
            if (ctrl_q[USF_TXSW_BIT]) begin
               // Break has priority over preamble, preamble over data
               if (brk_q | ctrl_q[USF_BRK_BIT]) begin
                  tx_sh_d = 11'h000;
                  brk_taken = 1'b1;
                  tx_st_d = USF_TX_SHIFT;
               end else if (pre_q) begin
                  tx_sh_d = 11'h7FF;
                  pre_taken = 1'b1;
                  tx_st_d = USF_TX_SHIFT;
               end else if (~flags_q[USF_TXE_BIT]) begin
                  if (ctrl_q[USF_M9_BIT]) begin
                     tx_sh_d = {1'b1, ctrl_q[USF_PON_BIT] & (^txbuf_q ^ ctrl_q[USF_PODD_BIT]),
                                txbuf_q, 1'b0};
                  end else begin
                     tx_sh_d = {2'b11, ctrl_q[USF_PON_BIT] ?
                                (^txbuf_q[6:0] ^ ctrl_q[USF_PODD_BIT]) : txbuf_q[7],
                                txbuf_q[6:0], 1'b0};
                  end
                  tx_take = 1'b1;
                  tx_st_d = USF_TX_SHIFT;
               end
            end
         end
         USF_TX_SHIFT: begin
            if (os_tick) begin
               tx_ph_d = tx_ph_q + 4'h1;
               if (tx_ph_q == USF_OS_LAST) begin
                  tx_sh_d = {1'b1, tx_sh_q[10:1]};
                  tx_bit_d = tx_bit_q + 4'h1;
                  if (tx_bit_q == tx_last) begin
                     tx_st_d = USF_TX_IDLE;
                  end
               end
            end
         end
         default: tx_st_d = USF_TX_IDLE;
      endcase
      txd_d = (tx_st_d == USF_TX_SHIFT) ? tx_sh_d[0] : 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_st_q <= USF_TX_IDLE;
         tx_sh_q <= 11'h7FF;
         tx_ph_q <= 4'h0;
         tx_bit_q <= 4'h0;
         txd_q <= 1'b1;
      end else begin
         tx_st_q <= tx_st_d;
         tx_sh_q <= tx_sh_d;
         tx_ph_q <= tx_ph_d;
         tx_bit_q <= tx_bit_d;
         txd_q <= txd_d;
      end
   end

   // ----------------------------------------------------------------
   // Receiver and idle detection
   // ----------------------------------------------------------------
   always_comb begin
      rx_st_d = rx_st_q;
      rx_ph_d = rx_ph_q;
      rx_bit_d = rx_bit_q;
      ones_d = ones_q;
      rx_sh_d = rx_sh_q;
      noise_d = noise_q;
      idle_en_d = idle_en_q;
      rx_done = 1'b0;
      rx_stop = 1'b1;
      rx_char = ctrl_q[USF_M9_BIT] ? rx_sh_q[7:0] : rx_sh_q[8:1];
      rx_perr = (^(ctrl_q[USF_M9_BIT] ? rx_sh_q : {1'b0, rx_sh_q[8:1]})) ^
                ctrl_q[USF_PODD_BIT];
      case (rx_st_q)
         USF_RX_IDLE: begin
            if (~rx_s2_q) begin
               rx_st_d = USF_RX_START;
               rx_ph_d = 4'h0;
               ones_d = 3'h0;
               noise_d = 1'b0;
               idle_en_d = 1'b0;
            end
         end
         USF_RX_START: begin
            if (os_tick) begin
               rx_ph_d = rx_ph_q + 4'h1;
               if (in_win(rx_ph_q, USF_START_FIRST, USF_START_LAST)) begin
                  ones_d = ones_q + {2'b00, rx_s2_q};
               end
               if (rx_ph_q == USF_OS_LAST) begin
                  ones_d = 3'h0;
                  rx_bit_d = 4'h0;
                  if (ones_q >= USF_START_REJECT) begin
                     rx_st_d = USF_RX_IDLE;
                  end else begin
                     noise_d = noisy(ones_q, USF_START_SAMPLES);
                     idle_en_d = ~ctrl_q[USF_IAS_BIT];
                     rx_st_d = USF_RX_DATA;
                  end
               end
            end
         end
         USF_RX_DATA: begin
            if (os_tick) begin
               rx_ph_d = rx_ph_q + 4'h1;
               if (in_win(rx_ph_q, USF_BIT_FIRST, USF_BIT_LAST)) begin
                  ones_d = ones_q + {2'b00, rx_s2_q};
               end
               if (rx_ph_q == USF_OS_LAST) begin
                  rx_sh_d = {ones_q >= USF_BIT_MAJORITY, rx_sh_q[8:1]};
                  noise_d = noise_q | noisy(ones_q, USF_BIT_SAMPLES);
                  ones_d = 3'h0;
                  rx_bit_d = rx_bit_q + 4'h1;
                  if (rx_bit_q == (ctrl_q[USF_M9_BIT] ? USF_DATA9_LAST : USF_DATA8_LAST)) begin
                     rx_st_d = USF_RX_STOP;
                  end
               end
            end
         end
         USF_RX_STOP: begin
            if (os_tick) begin
               rx_ph_d = rx_ph_q + 4'h1;
               if (in_win(rx_ph_q, USF_BIT_FIRST, USF_BIT_LAST)) begin
                  ones_d = ones_q + {2'b00, rx_s2_q};
               end
               // Finish early in the stop bit to leave room for resync
               if (rx_ph_q == USF_STOP_DONE) begin
                  rx_stop = (ones_q >= USF_BIT_MAJORITY);
                  noise_d = noise_q | noisy(ones_q, USF_BIT_SAMPLES);
                  rx_done = 1'b1;
                  idle_en_d = idle_en_q | ctrl_q[USF_IAS_BIT];
                  rx_st_d = USF_RX_IDLE;
               end
            end
         end
         default: rx_st_d = USF_RX_IDLE;
      endcase
      // Any low sample restarts the idle count
      idle_ticks = ctrl_q[USF_M9_BIT] ? USF_IDLE9_TICKS : USF_IDLE8_TICKS;
      idle_cnt_d = idle_cnt_q;
      if (~rx_s2_q) begin
         idle_cnt_d = 8'h00;
      end else if (os_tick & idle_en_q & (idle_cnt_q != idle_ticks)) begin
         idle_cnt_d = idle_cnt_q + 8'h01;
      end
      // Fires once per idle gap after an accepted character, however long the line idles
      idle_hit = idle_arm_q & idle_en_q & rx_s2_q & (idle_cnt_q == idle_ticks);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_st_q <= USF_RX_IDLE;
         rx_ph_q <= 4'h0;
         rx_bit_q <= 4'h0;
         ones_q <= 3'h0;
         rx_sh_q <= 9'h000;
         noise_q <= 1'b0;
         idle_en_q <= 1'b0;
         idle_cnt_q <= 8'h00;
      end else begin
         rx_st_q <= rx_st_d;
         rx_ph_q <= rx_ph_d;
         rx_bit_q <= rx_bit_d;
         ones_q <= ones_d;
         rx_sh_q <= rx_sh_d;
         noise_q <= noise_d;
         idle_en_q <= idle_en_d;
         idle_cnt_q <= idle_cnt_d;
      end
   end

endmodule : usf_status_flags

//--- test/tb_usf_status_flags.sv
`timescale 1ns/1ps
module tb_usf_status_flags;
   import usf_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready, pslverr, rxd, txd, err_v;
   logic [31:0] rd_v;
   int n_fail = 0;
   int n_tests = 0;
   int cyc = 0;

   always #2 pclk = ~pclk;

   usf_status_flags usf_status_flags_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd));
   usf_serial_node usf_serial_node_i (.pclk(pclk), .rxd(rxd), .txd(txd));

   task automatic complete_run;
      if (n_fail == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : complete_run

   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         n_fail++;
         complete_run();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd_v = prdata;
      err_v = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Poll status until the masked bits match; the caller judges the last read
   task automatic wait_stat(input logic [7:0] m, input logic [7:0] v);
      int n;
      n = 0;
      do begin
         apb(1'b0, USF_STAT_OFS, 32'h0000_0000);
         n++;
      end while ((rd_v[7:0] & m) !== v && n < 300);
   endtask : wait_stat

   task automatic t_reset;
      apb(1'b1, USF_DATA_OFS, 32'h0000_00A5);
      apb(1'b1, USF_STAT_OFS, 32'h0000_00FF);
      apb(1'b0, USF_STAT_OFS, 32'h0000_0000);
      check(rd_v, {24'h0, USF_STAT_RST});
      apb(1'b0, 8'h10, 32'h0000_0000);
      check({rd_v[30:0], err_v}, 32'h0000_0001);
   endtask : t_reset

   task automatic t_txc(input logic [7:0] a, input logic [7:0] d);
      apb(1'b0, USF_STAT_OFS, 32'h0000_0000);
      apb(1'b1, a, {24'h0, d});
      apb(1'b0, USF_STAT_OFS, 32'h0000_0000);
      check({31'h0, rd_v[USF_TXC_BIT]}, 32'h0000_0000);
      apb(1'b1, USF_CTRL_OFS, 32'h0000_0020);
      wait_stat(8'hC0, 8'hC0);
      check(rd_v & 32'h0000_00C0, 32'h0000_00C0);
      if (a == USF_DATA_OFS) begin
         check({24'h0, usf_serial_node_i.got_q}, {24'h0, d});
      end
   endtask : t_txc

   task automatic t_rx(input logic [7:0] ctl, input logic [8:0] v, input logic stp,
                       input logic nz, input logic [7:0] flg);
      apb(1'b1, USF_CTRL_OFS, {24'h0, ctl});
      usf_serial_node_i.send_char(v, ctl[USF_M9_BIT] ? 9 : 8, stp, nz);
      wait_stat(8'h2F, 8'h20 | flg);
      check(rd_v & 32'h0000_002F, {24'h0, 8'h20 | flg});
      apb(1'b0, USF_DATA_OFS, 32'h0000_0000);
      check(rd_v, {24'h0, v[7:0]});
      apb(1'b0, USF_STAT_OFS, 32'h0000_0000);
      check(rd_v & 32'h0000_002F, 32'h0000_0000);
   endtask : t_rx

   // Probe the idle flag a fixed time after the stop bit
   task automatic t_idle(input logic [7:0] ctl, input int w, input logic exp);
      apb(1'b1, USF_CTRL_OFS, {24'h0, ctl});
      usf_serial_node_i.send_char(9'h1FF, ctl[USF_M9_BIT] ? 9 : 8, 1'b1, 1'b0);
      repeat (w) @(posedge pclk);
      apb(1'b0, USF_STAT_OFS, 32'h0000_0000);
      check({31'h0, rd_v[USF_IDLE_BIT]}, {31'h0, exp});
      wait_stat(8'h30, 8'h30);
      check(rd_v & 32'h0000_0030, 32'h0000_0030);
      apb(1'b0, USF_DATA_OFS, 32'h0000_0000);
      repeat (400) @(posedge pclk);
      apb(1'b0, USF_STAT_OFS, 32'h0000_0000);
      check(rd_v & 32'h0000_0030, 32'h0000_0000);
   endtask : t_idle

   task automatic t_ovr;
      // Back to eight-bit frames with the idle count after the start bit
      apb(1'b1, USF_CTRL_OFS, 32'h0000_0020);
      usf_serial_node_i.send_char(9'h011, 8, 1'b1, 1'b0);
      usf_serial_node_i.send_char(9'h022, 8, 1'b1, 1'b1);
      wait_stat(8'h2F, 8'h28);
      check(rd_v & 32'h0000_002F, 32'h0000_0028);
      apb(1'b0, USF_DATA_OFS, 32'h0000_0000);
      check(rd_v, 32'h0000_0011);
      apb(1'b0, USF_STAT_OFS, 32'h0000_0000);
      check(rd_v & 32'h0000_0028, 32'h0000_0000);
   endtask : t_ovr

   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_txc(USF_CTRL_OFS, 8'h20);
      t_txc(USF_DATA_OFS, 8'h3C);
      t_txc(USF_CTRL_OFS, 8'h30);
      t_rx(8'h20, 9'h05A, 1'b1, 1'b0, 8'h00);
      t_rx(8'h20, 9'h05A, 1'b1, 1'b1, 8'h04);
      t_rx(8'h20, 9'h05A, 1'b0, 1'b0, 8'h02);
      t_rx(8'h22, 9'h001, 1'b1, 1'b0, 8'h01);
      t_rx(8'h22, 9'h081, 1'b1, 1'b0, 8'h00);
      t_rx(8'h28, 9'h1A5, 1'b1, 1'b0, 8'h00);
      t_idle(8'h20, 40, 1'b1);
      t_idle(8'h24, 130, 1'b0);
      t_idle(8'h2C, 158, 1'b0);
      t_ovr();
      complete_run();
   end
endmodule : tb_usf_status_flags

//--- test/usf_assertions.sv
`timescale 1ns/1ps
module usf_assertions
   import usf_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Serial line
   input wire logic rxd,
   input wire logic txd
);
   logic acc, st_rd, mapped;
   logic [7:0] prev_q;
   logic rd_q, wr_q, cw_q, first_q;
   assign acc = psel && penable;
   assign st_rd = acc && !pwrite && paddr == USF_STAT_OFS;
   assign mapped = paddr inside {USF_STAT_OFS, USF_DATA_OFS, USF_CTRL_OFS, USF_BAUD_OFS};

   // Remember the last status seen and which accesses followed it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_q <= 8'h00;
         rd_q <= 1'b0;
         wr_q <= 1'b0;
         cw_q <= 1'b0;
         first_q <= 1'b1;
      end else if (st_rd) begin
         prev_q <= prdata[7:0];
         rd_q <= 1'b0;
         wr_q <= 1'b0;
         cw_q <= 1'b0;
         first_q <= 1'b0;
      end else if (acc) begin
         rd_q <= rd_q || (!pwrite && paddr == USF_DATA_OFS);
         wr_q <= wr_q || (pwrite && paddr == USF_DATA_OFS);
         cw_q <= cw_q || (pwrite && paddr == USF_CTRL_OFS);
         first_q <= first_q && !(pwrite && paddr == USF_CTRL_OFS);
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_ready; acc |-> pready; endproperty
   a_ready: assert property (p_ready) else $error("access not answered");
   property p_err; acc |-> pslverr == !mapped; endproperty
   a_err: assert property (p_err) else $error("error response wrong");
   property p_hold; acc && !pwrite |=> $stable(prdata); endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   property p_first; st_rd && first_q |-> prdata[7:0] == USF_STAT_RST; endproperty
   a_first: assert property (p_first) else $error("status after reset wrong");
   property p_txe; st_rd && prev_q[7] && !prdata[7] |-> wr_q; endproperty
   a_txe: assert property (p_txe) else $error("buffer-empty fell");
   property p_txc; st_rd && prev_q[6] && !prdata[6] |-> wr_q || cw_q; endproperty
   a_txc: assert property (p_txc) else $error("complete fell");
   property p_rxf; st_rd && prev_q[5] && !prdata[5] |-> rd_q; endproperty
   a_rxf: assert property (p_rxf) else $error("receive-full fell");
   property p_idle; st_rd && prev_q[4] && !prdata[4] |-> rd_q; endproperty
   a_idle: assert property (p_idle) else $error("idle fell");
   property p_ovr; st_rd && prev_q[3] && !prdata[3] |-> rd_q; endproperty
   a_ovr: assert property (p_ovr) else $error("overrun fell");
   property p_rxerr; st_rd && |(prev_q[2:0] & ~prdata[2:0]) |-> rd_q; endproperty
   a_rxerr: assert property (p_rxerr) else $error("error flag fell");

   c_ovr: cover property (st_rd && prdata[3]);
   c_noise: cover property (st_rd && prdata[2]);
   c_brk: cover property (acc && pwrite && paddr == USF_CTRL_OFS && pwdata[4]);
endmodule : usf_assertions

bind usf_status_flags usf_assertions usf_assertions_i (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .rxd(rxd), .txd(txd)
);

//--- test/usf_serial_node.sv
`timescale 1ns/1ps
module usf_serial_node (
   // Clock
   input wire logic pclk,
   // Line
   output logic rxd,
   input wire logic txd
);
   logic [7:0] got_q;

   initial begin
      rxd = 1'b1;
      got_q = 8'h00;
   end

   // Sixteen cycles a bit, matching the divider left at its reset value
   task automatic send_char(input logic [8:0] v, input int nb, input logic stp,
                            input logic nz);
      logic b;
      for (int i = 0; i < nb + 2; i++) begin
         b = (i == 0) ? 1'b0 : (i > nb) ? stp : v[i - 1];
         for (int c = 0; c < 16; c++) begin
            @(posedge pclk);
            rxd <= (nz && i == 2 && c == 10) ? ~b : b;
         end
      end
      @(posedge pclk);
      rxd <= 1'b1;
   endtask : send_char

   // Sample mid-bit; a break is read as a zero character
   initial begin
      forever begin
         @(negedge txd);
         repeat (24) @(posedge pclk);
         for (int k = 0; k < 8; k++) begin
            got_q[k] = txd;
            repeat (16) @(posedge pclk);
         end
         wait (txd === 1'b1);
      end
   end
endmodule : usf_serial_node
